// File: design/ttu_pkg.sv
package ttu_pkg;
  // Printed offsets are word indices; the byte address is four times the index
  localparam logic [7:0] IDX_T0_COUNT = 8'h50;
  localparam logic [7:0] IDX_T0_LIMIT_A = 8'h52;
  localparam logic [7:0] IDX_T0_LIMIT_B = 8'h54;
  localparam logic [7:0] IDX_T0_CONTROL = 8'h56;
  localparam logic [7:0] IDX_T1_COUNT = 8'h58;
  localparam logic [7:0] IDX_T1_LIMIT_A = 8'h5a;
  localparam logic [7:0] IDX_T1_LIMIT_B = 8'h5c;
  localparam logic [7:0] IDX_T1_CONTROL = 8'h5e;
  localparam logic [7:0] IDX_T2_COUNT = 8'h60;
  localparam logic [7:0] IDX_T2_LIMIT_A = 8'h62;
  localparam logic [7:0] IDX_T2_CONTROL = 8'h66;
  // Register spacing inside the block and the span of the block
  localparam logic [7:0] IDX_SPAN = 8'h18;
  localparam logic [1:0] SEL_COUNT = 2'h0;
  localparam logic [1:0] SEL_LIMIT_A = 2'h1;
  localparam logic [1:0] SEL_LIMIT_B = 2'h2;
  localparam logic [1:0] SEL_CONTROL = 2'h3;
  localparam logic [1:0] TMR_CHAIN = 2'h2;

  // Control word field positions
  localparam int BIT_RUN = 15;
  localparam int BIT_RUN_WRITE_MASK = 14;
  localparam int BIT_INT_EN = 13;
  localparam int BIT_COMPARE_SELECT = 12;
  localparam int BIT_LIMIT_HIT = 5;
  localparam int BIT_EDGE_RESTART = 4;
  localparam int BIT_CHAIN_CLK = 3;
  localparam int BIT_OUTSIDE_CLK = 2;
  localparam int BIT_DUAL_LIMIT = 1;
  localparam int BIT_FREE_RUN = 0;

  // Reset values: run bits clear, timers 0 and 1 in dual-limit mode
  localparam logic [2:0] RST_DUAL_LIMIT = 3'h3;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Service slot: one timer step every fourth clock
  localparam int SVC_PERIOD = 4;
  localparam logic [1:0] SVC_LAST = 2'(SVC_PERIOD - 1);

  typedef struct packed {
    logic hit;
    logic [1:0] tmr;
    logic [1:0] sel;
  } ttu_dec_t;

  typedef struct packed {
    logic [1:0] div;
    logic wait_done;
    logic [2:0][15:0] cnt;
    logic [2:0][15:0] lima;
    logic [2:0][15:0] limb;
    logic [2:0] run;
    logic [2:0] int_en;
    logic [2:0] compare_select_flag;
    logic [2:0] limit_hit_flag;
    logic [2:0] edge_restart_mode;
    logic [2:0] chain_clk;
    logic [2:0] outside_clock_sel;
    logic [2:0] dual_limit_mode;
    logic [2:0] free_run_mode;
    logic [2:0] started;
    logic [2:0] edge_pend;
    logic [2:0] low_pulse;
    logic [2:0] irq;
    logic [2:0] in_s1;
    logic [2:0] in_s2;
    logic [2:0] in_prev;
    logic [31:0] prdata;
  } ttu_state_t;
endpackage : ttu_pkg

// File: design/ttu_top.sv
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ttu_top
  import ttu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] tmr_in,
  output logic [1:0] tmr_out,
  output logic [2:0] tmr_irq
);

  function automatic ttu_dec_t decode(input logic [11:0] addr);
    ttu_dec_t d;
    logic [7:0] off;
    off = addr[9:2] - IDX_T0_COUNT;
    d.tmr = off[4:3];
    d.sel = off[2:1];
    d.hit = (addr[11:10] == 2'h0) && (addr[1:0] == 2'h0) && (off < IDX_SPAN) && !off[0]
            && !(d.tmr == TMR_CHAIN && d.sel == SEL_LIMIT_B);
    return d;
  endfunction : decode

  function automatic logic [15:0] ctrl_word(input ttu_state_t st, input int t);
    logic [15:0] w;
    w = RST_WORD;
    w[BIT_RUN] = st.run[t];
    w[BIT_INT_EN] = st.int_en[t];
    w[BIT_COMPARE_SELECT] = st.compare_select_flag[t];
    w[BIT_LIMIT_HIT] = st.limit_hit_flag[t];
    w[BIT_EDGE_RESTART] = st.edge_restart_mode[t];
    w[BIT_CHAIN_CLK] = st.chain_clk[t];
    w[BIT_OUTSIDE_CLK] = st.outside_clock_sel[t];
    w[BIT_DUAL_LIMIT] = st.dual_limit_mode[t];
    w[BIT_FREE_RUN] = st.free_run_mode[t];
    return w;
  endfunction : ctrl_word

  ttu_state_t s_ff;
  ttu_state_t nxt_s;
  ttu_dec_t dec;
  logic tick;
  logic bus_rd_phase;
  logic bus_wr;
  logic [2:0] hitv;

  assign dec = decode(paddr);
  assign tick = (s_ff.div == SVC_LAST);
  assign pready = psel && penable && s_ff.wait_done;
  assign pslverr = pready && !dec.hit;
  assign bus_rd_phase = psel && penable && !s_ff.wait_done;
  assign bus_wr = pready && pwrite && dec.hit;
  assign prdata = s_ff.prdata;
  assign tmr_irq = s_ff.irq;

  always_comb begin
    for (int t = 0; t < 2; t++) begin
      tmr_out[t] = s_ff.dual_limit_mode[t] ? !s_ff.compare_select_flag[t] : !s_ff.low_pulse[t];
    end
  end

  always_comb begin
    logic ev;
    logic lvl;
    logic rise;
    logic chain_tc;
    logic clk_ev;
    logic [15:0] nxt_cnt;
    logic [15:0] lim;
    logic [15:0] w16;
    nxt_s = s_ff;
    ev = 1'b0;
    lvl = 1'b0;
    rise = 1'b0;
    chain_tc = 1'b0;
    clk_ev = 1'b0;
    nxt_cnt = RST_WORD;
    lim = RST_WORD;
    w16 = pwdata[15:0];
    hitv = 3'h0;
    nxt_s.div = s_ff.div + 2'h1;
    nxt_s.in_s1 = {1'b0, tmr_in};
    nxt_s.in_s2 = s_ff.in_s1;
    nxt_s.in_prev = s_ff.in_s2;
    nxt_s.irq = 3'h0;
    nxt_s.low_pulse = 3'h0;
    // Timer 2 first so its terminal count can feed the chained timers this slot
    for (int t = 2; t >= 0; t--) begin
      ev = 1'b0;
      lvl = (t == 2) ? 1'b1 : s_ff.in_s2[t];
      rise = s_ff.in_s2[t] && !s_ff.in_prev[t];
      clk_ev = s_ff.chain_clk[t] ? chain_tc : 1'b1;
      if (!s_ff.run[t]) begin
        // edges seen while halted are dropped
        nxt_s.edge_pend[t] = 1'b0;
        nxt_s.started[t] = 1'b0;
      end else begin
        // latch an edge until its slot
        if (rise) begin
          nxt_s.edge_pend[t] = 1'b1;
        end
        if (tick) begin
          if (s_ff.outside_clock_sel[t]) begin
            ev = s_ff.edge_pend[t];
            nxt_s.edge_pend[t] = rise;
          end else if (s_ff.edge_restart_mode[t]) begin
            nxt_s.edge_pend[t] = rise;
            if (s_ff.edge_pend[t]) begin
              nxt_s.cnt[t] = RST_WORD;
              nxt_s.started[t] = 1'b1;
            end else begin
              ev = s_ff.started[t] && clk_ev;
            end
          end else begin
            ev = lvl && clk_ev;
            nxt_s.edge_pend[t] = 1'b0;
          end
        end
      end
      if (ev) begin
        nxt_cnt = s_ff.cnt[t] + 16'h0001;
        lim = s_ff.compare_select_flag[t] ? s_ff.limb[t] : s_ff.lima[t];
        if (nxt_cnt == lim) begin
          // back to zero on the hit
          nxt_s.cnt[t] = RST_WORD;
          hitv[t] = 1'b1;
          nxt_s.limit_hit_flag[t] = 1'b1;
          nxt_s.irq[t] = s_ff.int_en[t];
          nxt_s.low_pulse[t] = !s_ff.dual_limit_mode[t];
          if (s_ff.dual_limit_mode[t]) begin
            nxt_s.compare_select_flag[t] = !s_ff.compare_select_flag[t];
          end
          if (!s_ff.free_run_mode[t] && (!s_ff.dual_limit_mode[t] || s_ff.compare_select_flag[t])) begin
            nxt_s.run[t] = 1'b0;
          end
          if (t == 2) begin
            chain_tc = 1'b1;
          end
        end else begin
          nxt_s.cnt[t] = nxt_cnt;
        end
      end
    end
    // Read data is captured in the wait cycle, before any write of this access
    if (bus_rd_phase) begin
      nxt_s.prdata = 32'h0000_0000;
      if (dec.hit) begin
        unique case (dec.sel)
          SEL_COUNT: nxt_s.prdata[15:0] = s_ff.cnt[dec.tmr];
          SEL_LIMIT_A: nxt_s.prdata[15:0] = s_ff.lima[dec.tmr];
          SEL_LIMIT_B: nxt_s.prdata[15:0] = s_ff.limb[dec.tmr];
          SEL_CONTROL: nxt_s.prdata[15:0] = ctrl_word(s_ff, int'(dec.tmr));
        endcase
      end
    end
    if (bus_wr) begin
      unique case (dec.sel)
        SEL_COUNT: nxt_s.cnt[dec.tmr] = w16;
        SEL_LIMIT_A: nxt_s.lima[dec.tmr] = w16;
        SEL_LIMIT_B: nxt_s.limb[dec.tmr] = w16;
        SEL_CONTROL: begin
          if (w16[BIT_RUN_WRITE_MASK]) begin
            nxt_s.run[dec.tmr] = w16[BIT_RUN];
          end
          // enable bit only gates future requests
          nxt_s.int_en[dec.tmr] = w16[BIT_INT_EN];
          // a hit in the same cycle beats the clear
          nxt_s.limit_hit_flag[dec.tmr] = w16[BIT_LIMIT_HIT] || hitv[dec.tmr];
          nxt_s.edge_restart_mode[dec.tmr] = w16[BIT_EDGE_RESTART];
          nxt_s.chain_clk[dec.tmr] = w16[BIT_CHAIN_CLK];
          nxt_s.outside_clock_sel[dec.tmr] = w16[BIT_OUTSIDE_CLK];
          nxt_s.dual_limit_mode[dec.tmr] = w16[BIT_DUAL_LIMIT];
          nxt_s.free_run_mode[dec.tmr] = w16[BIT_FREE_RUN];
        end
      endcase
    end
    nxt_s.dual_limit_mode[2] = 1'b0;
    nxt_s.outside_clock_sel[2] = 1'b0;
    nxt_s.chain_clk[2] = 1'b0;
    nxt_s.edge_restart_mode[2] = 1'b0;
    nxt_s.limb[2] = RST_WORD;
    nxt_s.compare_select_flag = nxt_s.compare_select_flag & nxt_s.dual_limit_mode;
    nxt_s.wait_done = psel && penable && !s_ff.wait_done;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
      s_ff.dual_limit_mode <= RST_DUAL_LIMIT;
    end else begin
      s_ff <= nxt_s;
    end
  end

  logic bus_ctrl0_nomask;
  assign bus_ctrl0_nomask = bus_wr && dec.tmr == 2'h0 && dec.sel == SEL_CONTROL && !pwdata[BIT_RUN_WRITE_MASK];

  property p_run_hold;
    @(posedge pclk) disable iff (!presetn)
      (!s_ff.run[0] && !bus_wr) |=> (s_ff.cnt[0] == $past(s_ff.cnt[0]));
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("halted timer 0 changed count");

  property p_auto_stop;
    @(posedge pclk) disable iff (!presetn)
      (s_ff.low_pulse[0] && !$past(s_ff.free_run_mode[0]) && !$past(bus_wr)) |-> !s_ff.run[0];
  endproperty
  a_auto_stop: assert property (p_auto_stop) else $error("run bit not cleared at maximum count");

  property p_mask_keep;
    @(posedge pclk) disable iff (!presetn)
      (bus_ctrl0_nomask && !tick) |=> (s_ff.run[0] == $past(s_ff.run[0]));
  endproperty
  a_mask_keep: assert property (p_mask_keep) else $error("unmasked write changed run bit");

  property p_irq_flag;
    @(posedge pclk) disable iff (!presetn)
      tmr_irq[1] |-> (s_ff.limit_hit_flag[1] && $past(s_ff.int_en[1]));
  endproperty
  a_irq_flag: assert property (p_irq_flag) else $error("request without hit or enable");

  property p_select_zero;
    @(posedge pclk) disable iff (!presetn)
      !s_ff.dual_limit_mode[1] |-> !s_ff.compare_select_flag[1];
  endproperty
  a_select_zero: assert property (p_select_zero) else $error("compare select set in single-limit mode");

  property p_out_dual;
    @(posedge pclk) disable iff (!presetn)
      s_ff.dual_limit_mode[0] |-> (tmr_out[0] == !s_ff.compare_select_flag[0]);
  endproperty
  a_out_dual: assert property (p_out_dual) else $error("output does not track active limit");

  property p_pulse_one;
    @(posedge pclk) disable iff (!presetn)
      (!tmr_out[1] && !s_ff.dual_limit_mode[1]) |=> (tmr_out[1] || s_ff.dual_limit_mode[1]);
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("output low longer than one clock");

  property p_hit_zero;
    @(posedge pclk) disable iff (!presetn)
      (s_ff.low_pulse[0] && !$past(bus_wr)) |-> (s_ff.cnt[0] == 16'h0000);
  endproperty
  a_hit_zero: assert property (p_hit_zero) else $error("count not zero after hit");

  property p_slot;
    @(posedge pclk) disable iff (!presetn)
      !bus_wr |=> ((s_ff.cnt[2] == $past(s_ff.cnt[2])) || ($past(s_ff.div) == SVC_LAST));
  endproperty
  a_slot: assert property (p_slot) else $error("timer 2 stepped outside its slot");

  property p_wait_state;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable) ##1 (psel && penable) |-> !pready ##1 (!(psel && penable) || pready);
  endproperty
  a_wait_state: assert property (p_wait_state) else $error("access answered without wait state");

  property p_t2_fixed;
    @(posedge pclk) disable iff (!presetn)
      !bus_wr |=> (!s_ff.dual_limit_mode[2] && !s_ff.outside_clock_sel[2] && !s_ff.chain_clk[2]
                   && !s_ff.edge_restart_mode[2] && !s_ff.compare_select_flag[2]);
  endproperty
  a_t2_fixed: assert property (p_t2_fixed) else $error("timer 2 fixed bit set");

endmodule : ttu_top
`default_nettype wire

// File: bench/ttu_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module ttu_pin_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] gate_lvl,
  input wire logic [1:0] edge_en,
  output logic [1:0] tmr_in,
  output logic [15:0] edge_cnt
);
  logic [2:0] ph_ff;
  logic [1:0] pin_ff;
  logic [15:0] edge_cnt_ff;
  logic [1:0] nxt_pin;
  assign nxt_pin = (edge_en & {2{ph_ff[2]}}) | (~edge_en & gate_lvl);
  assign tmr_in = pin_ff;
  assign edge_cnt = edge_cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_ff <= 3'h0;
      pin_ff <= 2'b00;
      edge_cnt_ff <= 16'h0000;
    end else begin
      ph_ff <= ph_ff + 3'h1;
      pin_ff <= nxt_pin;
      if (nxt_pin[1] && !pin_ff[1]) begin
        edge_cnt_ff <= edge_cnt_ff + 16'h0001;
      end
    end
  end
endmodule : ttu_pin_model
`default_nettype wire

// File: bench/triple_timer_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module triple_timer_unit_tb
  import ttu_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] tmr_in, tmr_out, gate_lvl, edge_en;
  logic [2:0] tmr_irq;
  logic [15:0] edge_cnt, r, c;
  logic e;
  int errors = 0;
  int total_checks = 0;
  int irq_n[3] = '{0, 0, 0};
  int i0, i2;
  ttu_top ttu_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tmr_in(tmr_in), .tmr_out(tmr_out), .tmr_irq(tmr_irq));
  ttu_pin_model ttu_pin_model_inst (.pclk(pclk), .presetn(presetn), .gate_lvl(gate_lvl),
    .edge_en(edge_en), .tmr_in(tmr_in), .edge_cnt(edge_cnt));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    for (int k = 0; k < 3; k++) begin
      if (tmr_irq[k] === 1'b1) irq_n[k]++;
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  // One APB transfer; pready and read data are taken at the rising edge that ends the access
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] wd, output logic [15:0] rd,
    output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata[15:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      summarize();
    end
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    logic [15:0] x;
    logic y;
    apb(1'b1, idx, d, x, y);
  endtask : wr
  task automatic rd(input logic [7:0] idx, output logic [15:0] d);
    logic y;
    apb(1'b0, idx, 16'h0000, d, y);
  endtask : rd
  // Polls the control word until the run bit drops; a halted timer must get there
  task automatic wait_halt(input logic [7:0] idx);
    logic [15:0] v;
    for (int n = 0; n < 100; n++) begin
      rd(idx, v);
      if (v[15] === 1'b0) return;
    end
    errors++;
    summarize();
  endtask : wait_halt
  task automatic t_reset();
    rd(IDX_T0_CONTROL, r);
    check("t0 ctrl rst", r, 16'h0002);
    rd(IDX_T1_CONTROL, r);
    check("t1 ctrl rst", r, 16'h0002);
    rd(IDX_T2_CONTROL, r);
    check("t2 ctrl rst", r, 16'h0000);
    check("out rst", 16'(tmr_out), 16'h0003);
    apb(1'b0, 8'h64, 16'h0000, r, e);
    check("unmapped err", 16'(e), 16'h0001);
    check("unmapped data", r, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_mask();
    wr(IDX_T2_CONTROL, 16'h8000);
    rd(IDX_T2_CONTROL, r);
    check("run unmasked", r, 16'h0000);
    wr(IDX_T2_CONTROL, 16'hdfdf);
    rd(IDX_T2_CONTROL, r);
    check("t2 fixed bits", r, 16'h8001);
    wr(IDX_T2_CONTROL, 16'h4000);
    rd(IDX_T2_CONTROL, r);
    check("run masked off", r, 16'h0000);
    $display("test mask done");
  endtask : t_mask
  task automatic t_single();
    wr(IDX_T2_LIMIT_A, 16'h0005);
    wr(IDX_T2_COUNT, 16'h0002);
    i2 = irq_n[2];
    wr(IDX_T2_CONTROL, 16'he000);
    wait_halt(IDX_T2_CONTROL);
    rd(IDX_T2_COUNT, r);
    check("t2 count", r, 16'h0000);
    rd(IDX_T2_CONTROL, r);
    check("t2 halted", r, 16'h2020);
    check("t2 irq", 16'(irq_n[2] - i2), 16'h0001);
    wr(IDX_T2_CONTROL, 16'h2000);
    rd(IDX_T2_CONTROL, r);
    check("t2 hit clear", r, 16'h2000);
    $display("test single done");
  endtask : t_single
  task automatic t_dual();
    int n;
    gate_lvl[0] <= 1'b1;
    wr(IDX_T0_LIMIT_A, 16'h0003);
    wr(IDX_T0_LIMIT_B, 16'h0002);
    wr(IDX_T0_COUNT, 16'h0000);
    i0 = irq_n[0];
    wr(IDX_T0_CONTROL, 16'he002);
    n = 0;
    @(negedge pclk);
    while (tmr_out[0] !== 1'b0 && n < 200) begin
      @(negedge pclk);
      n++;
    end
    check("out low on b", 16'(tmr_out[0]), 16'h0000);
    rd(IDX_T0_CONTROL, r);
    check("select b", r & 16'h1000, 16'h1000);
    wait_halt(IDX_T0_CONTROL);
    rd(IDX_T0_CONTROL, r);
    check("t0 halted", r, 16'h2022);
    check("t0 irq a b", 16'(irq_n[0] - i0), 16'h0002);
    check("out high on a", 16'(tmr_out[0]), 16'h0001);
    $display("test dual done");
  endtask : t_dual
  task automatic t_gate();
    gate_lvl[1] <= 1'b0;
    wr(IDX_T1_LIMIT_A, 16'h0000);
    wr(IDX_T1_COUNT, 16'h0000);
    wr(IDX_T1_CONTROL, 16'hc001);
    cyc(40);
    rd(IDX_T1_COUNT, r);
    check("gate low hold", r, 16'h0000);
    gate_lvl[1] <= 1'b1;
    cyc(40);
    rd(IDX_T1_COUNT, r);
    check("gate high count", 16'(r >= 16'h0005), 16'h0001);
    wr(IDX_T1_COUNT, 16'h1000);
    rd(IDX_T1_COUNT, r);
    check("count write", 16'(r >= 16'h1000 && r < 16'h1004), 16'h0001);
    wr(IDX_T1_CONTROL, 16'h4001);
    rd(IDX_T1_COUNT, c);
    edge_en[1] <= 1'b1;
    cyc(40);
    edge_en[1] <= 1'b0;
    rd(IDX_T1_COUNT, r);
    check("stopped hold", r, c);
    $display("test gate done");
  endtask : t_gate
  task automatic t_ext();
    gate_lvl[1] <= 1'b0;
    wr(IDX_T1_COUNT, 16'h0000);
    wr(IDX_T1_CONTROL, 16'hc015);
    c = edge_cnt;
    edge_en[1] <= 1'b1;
    cyc(80);
    edge_en[1] <= 1'b0;
    cyc(12);
    rd(IDX_T1_COUNT, r);
    check("ext edges", r, edge_cnt - c);
    wr(IDX_T1_CONTROL, 16'h4000);
    $display("test ext done");
  endtask : t_ext
  task automatic t_restart();
    gate_lvl[0] <= 1'b0;
    wr(IDX_T0_LIMIT_A, 16'h0000);
    wr(IDX_T0_COUNT, 16'h0100);
    wr(IDX_T0_CONTROL, 16'hc011);
    cyc(20);
    rd(IDX_T0_COUNT, r);
    check("restart waits edge", r, 16'h0100);
    gate_lvl[0] <= 1'b1;
    cyc(40);
    rd(IDX_T0_COUNT, r);
    check("restart from zero", 16'(r > 16'h0000 && r < 16'h000c), 16'h0001);
    gate_lvl[0] <= 1'b0;
    cyc(4);
    gate_lvl[0] <= 1'b1;
    cyc(12);
    rd(IDX_T0_COUNT, r);
    check("restart again", 16'(r < 16'h0004), 16'h0001);
    wr(IDX_T0_CONTROL, 16'h4000);
    $display("test restart done");
  endtask : t_restart
  task automatic t_chain();
    int n;
    gate_lvl[1] <= 1'b1;
    wr(IDX_T2_LIMIT_A, 16'h0002);
    wr(IDX_T2_COUNT, 16'h0000);
    wr(IDX_T1_LIMIT_A, 16'h0003);
    wr(IDX_T1_COUNT, 16'h0000);
    i0 = irq_n[1];
    wr(IDX_T1_CONTROL, 16'he009);
    wr(IDX_T2_CONTROL, 16'hc001);
    n = 0;
    @(negedge pclk);
    while (tmr_out[1] !== 1'b0 && n < 200) begin
      @(negedge pclk);
      n++;
    end
    check("t1 pulse low", 16'(tmr_out[1]), 16'h0000);
    @(negedge pclk);
    check("t1 pulse one clock", 16'(tmr_out[1]), 16'h0001);
    n = 1;
    while (tmr_out[1] !== 1'b0 && n < 100) begin
      @(negedge pclk);
      n++;
    end
    check("chained period", 16'(n), 16'h0018);
    cyc(2);
    check("t1 irq count", 16'(irq_n[1] - i0), 16'h0002);
    wr(IDX_T1_CONTROL, 16'h4000);
    wr(IDX_T2_CONTROL, 16'h4000);
    $display("test chain done");
  endtask : t_chain
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    gate_lvl = 2'b00;
    edge_en = 2'b00;
    cyc(8);
    presetn <= 1'b1;
    t_reset();
    t_mask();
    t_single();
    t_dual();
    t_gate();
    t_ext();
    t_restart();
    t_chain();
    summarize();
  end
endmodule : triple_timer_unit_tb
`default_nettype wire
